// *** hdl/dmiu_regs.svh ***
`ifndef DMIU_REGS_SVH
`define DMIU_REGS_SVH
// ----------------------------------------
// opcode patterns (14-bit instruction word)
// ----------------------------------------
`define DMIU_OP_STORE_F_HI   7'h01
`define DMIU_OP_LIT_ACC_HI   6'h30
`define DMIU_OP_LIT_BANK_HI  8'h01
`define DMIU_OP_LIT_LATCH_HI 7'h63
`define DMIU_OP_IND_HI       10'h001
`define DMIU_OP_OFS_HI       7'h7f
// ----------------------------------------
// field positions
// ----------------------------------------
`define DMIU_MM_LSB          0
`define DMIU_PTR_BIT         2
`define DMIU_DIR_BIT         3
`define DMIU_OFS_DIR_BIT     6
`define DMIU_OFS_PTR_BIT     6
// ----------------------------------------
// reset values
// ----------------------------------------
`define DMIU_RST_ACC         8'h00
`define DMIU_RST_BANK        6'h00
`define DMIU_RST_LATCH       7'h00
`define DMIU_RST_PTR         16'h0000
`endif

// *** hdl/dmiu_pkg.sv ***
`default_nettype none
package dmiu_pkg;
   typedef enum logic [1:0] {
      DMIU_PRE_INC  = 2'h0,
      DMIU_PRE_DEC  = 2'h1,
      DMIU_POST_INC = 2'h2,
      DMIU_POST_DEC = 2'h3
   } dmiu_mode_t;
   typedef enum logic [2:0] {
      DMIU_NONE, DMIU_LIT_BANK, DMIU_LIT_LATCH, DMIU_LIT_ACC,
      DMIU_ACC_STORE, DMIU_IND_LOAD, DMIU_IND_STORE, DMIU_OFS_MOVE
   } dmiu_op_t;
endpackage : dmiu_pkg
`default_nettype wire

// *** hdl/dmiu_ptr_calc.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dmiu_regs.svh"
// ----------------------------------------
// address and next pointer for one move
// ----------------------------------------
module dmiu_ptr_calc #(
   parameter int PTR_W = 16
) (
   input  wire logic [PTR_W-1:0] ptr,
   input  wire logic [1:0]       mode,
   input  wire logic             ofs_mode,
   input  wire logic [5:0]       offset,
   output logic      [PTR_W-1:0] addr,
   output logic      [PTR_W-1:0] next_ptr
);
   logic [PTR_W-1:0] step;
   logic [PTR_W-1:0] moved;
   // minus one is all ones, so one adder serves both directions
   assign step  = mode[`DMIU_MM_LSB] ? {PTR_W{1'b1}} : {{(PTR_W-1){1'b0}}, 1'b1};
   // wraps modulo the pointer range
   assign moved = ptr + step; // [RULE4]
   always_comb begin
      if (ofs_mode) begin
         // sign extend the 6-bit offset
         addr     = ptr + {{(PTR_W-6){offset[5]}}, offset}; // [RULE12] [RULE5]
         next_ptr = ptr; // [RULE13]
      end else begin
         addr     = mode[1] ? ptr : moved; // [RULE12] [RULE2]
         next_ptr = moved; // [RULE13]
      end
   end
endmodule : dmiu_ptr_calc
`default_nettype wire

// *** hdl/dmiu_core.sv ***
// Function
// [RULE1] indirect moves carry a byte between accumulator and pointer-addressed memory
// [RULE2] mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// [RULE3] indirect port is not storage; it maps to pointer address in memory
// [RULE4] pointers are 16 bits and wrap on increment and decrement
// [RULE5] offset form takes signed offset -32..31 and pointer index 0 or 1
// [RULE6] literal-to-bank loads 6 bits into bank select, no flags touched
// [RULE7] literal-to-latch loads 7 bits into the pc high latch, no flags
// [RULE8] literal-to-accumulator loads 8 bits, one word, one cycle, no flags
// [RULE9] don't-care bits of literal-to-accumulator encoding are zero
// [RULE10] accumulator store writes file register 0..127, one cycle, no flags
// [RULE11] pointer steps never change any status flag
// [RULE12] offset address is pointer plus offset; pre-modes use updated pointer
// [RULE13] pointer ends plus or minus one; unchanged in offset mode
// [RULE14] store address joins bank select with the 7-bit file address
// [RULE15] indirect moves finish update and transfer within their one cycle
`timescale 1ns/10ps
`default_nettype none
`include "dmiu_regs.svh"
module dmiu_core #(
   parameter int PTR_W  = 16,
   parameter int NUM_PTR = 2
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             instr_valid,
   input  wire logic [13:0]      instr,
   input  wire logic [7:0]       mem_rdata,
   output logic      [PTR_W-1:0] mem_addr,
   output logic                  mem_rd,
   output logic                  mem_wr,
   output logic      [7:0]       mem_wdata,
   output logic      [7:0]       acc,
   output logic      [5:0]       bank_select_reg,
   output logic      [6:0]       program_counter_high_latch,
   output logic      [PTR_W-1:0] indirect_pointer0,
   output logic      [PTR_W-1:0] indirect_pointer1,
   output logic                  flags_we
);
   // decode and select logic only serve two 16-bit pointers
   if (PTR_W != 16 || NUM_PTR != 2) begin : g_bad_param
      $error("dmiu_core: only 16-bit pointers, two of them");
   end
   // ----------------------------------------
   // decode
   // ----------------------------------------
   dmiu_pkg::dmiu_op_t op;
   logic [PTR_W-1:0]   ptrs [NUM_PTR];
   logic               sel;
   logic [PTR_W-1:0]   ind_addr;
   logic [PTR_W-1:0]   next_ptr;
   logic               ofs_mode;
   logic               is_load;
   always_comb begin
      op = dmiu_pkg::DMIU_NONE;
      if (instr_valid) begin
         if (instr[13:7] == `DMIU_OP_STORE_F_HI)
            op = dmiu_pkg::DMIU_ACC_STORE;
         else if (instr[13:8] == `DMIU_OP_LIT_ACC_HI)
            op = dmiu_pkg::DMIU_LIT_ACC; // [RULE9]
         else if (instr[13:6] == `DMIU_OP_LIT_BANK_HI)
            op = dmiu_pkg::DMIU_LIT_BANK;
         else if (instr[13:7] == `DMIU_OP_LIT_LATCH_HI)
            op = dmiu_pkg::DMIU_LIT_LATCH;
         else if (instr[13:4] == `DMIU_OP_IND_HI)
            op = instr[`DMIU_DIR_BIT] ? dmiu_pkg::DMIU_IND_STORE : dmiu_pkg::DMIU_IND_LOAD;
         else if (instr[13:7] == `DMIU_OP_OFS_HI)
            op = dmiu_pkg::DMIU_OFS_MOVE;
      end
   end
   assign ofs_mode = (op == dmiu_pkg::DMIU_OFS_MOVE);
   assign sel      = ofs_mode ? instr[`DMIU_OFS_PTR_BIT] : instr[`DMIU_PTR_BIT]; // [RULE1] [RULE5]
   assign is_load  = (op == dmiu_pkg::DMIU_IND_LOAD);
   dmiu_ptr_calc #(
      .PTR_W (PTR_W)
   ) u_calc (
      .ptr      (ptrs[sel]),
      .mode     (instr[`DMIU_MM_LSB+1:`DMIU_MM_LSB]),
      .ofs_mode (ofs_mode),
      .offset   (instr[5:0]),
      .addr     (ind_addr),
      .next_ptr (next_ptr)
   );
   // ----------------------------------------
   // memory port
   // ----------------------------------------
   // indirect port has no storage of its own; it resolves straight to memory
   always_comb begin
      mem_addr = '0;
      mem_rd   = 1'b0;
      mem_wr   = 1'b0;
      case (op)
         dmiu_pkg::DMIU_ACC_STORE: begin
            mem_addr = {{(PTR_W-13){1'b0}}, bank_select_reg, instr[6:0]}; // [RULE14] [RULE10]
            mem_wr   = 1'b1;
         end
         dmiu_pkg::DMIU_IND_LOAD: begin
            mem_addr = ind_addr; // [RULE3]
            mem_rd   = 1'b1;
         end
         dmiu_pkg::DMIU_IND_STORE,
         dmiu_pkg::DMIU_OFS_MOVE: begin
            mem_addr = ind_addr; // [RULE3]
            mem_wr   = 1'b1; // [RULE1]
         end
         default: begin
            mem_addr = '0;
         end
      endcase
   end
   assign mem_wdata = acc;
   // no move here ever writes status flags
   assign flags_we  = 1'b0; // [RULE11] [RULE6] [RULE7] [RULE8] [RULE10]
   // ----------------------------------------
   // accumulator
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc <= `DMIU_RST_ACC;
      end else if (op == dmiu_pkg::DMIU_LIT_ACC) begin
         acc <= instr[7:0]; // [RULE8]
      end else if (is_load) begin
         acc <= mem_rdata; // [RULE1]
      end
   end
   // ----------------------------------------
   // bank select and latch
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bank_select_reg <= `DMIU_RST_BANK;
      end else if (op == dmiu_pkg::DMIU_LIT_BANK) begin
         bank_select_reg <= instr[5:0]; // [RULE6]
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         program_counter_high_latch <= `DMIU_RST_LATCH;
      end else if (op == dmiu_pkg::DMIU_LIT_LATCH) begin
         program_counter_high_latch <= instr[6:0]; // [RULE7]
      end
   end
   // ----------------------------------------
   // pointers
   // ----------------------------------------
   // update lands at the same edge as the transfer, so the next word sees both
   genvar g;
   generate
      for (g = 0; g < NUM_PTR; g++) begin : g_ptr
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               ptrs[g] <= `DMIU_RST_PTR;
            end else if ((is_load || op == dmiu_pkg::DMIU_IND_STORE) && sel == 1'(g)) begin
               ptrs[g] <= next_ptr; // [RULE13] [RULE15] [RULE4]
            end
         end
      end
   endgenerate
   assign indirect_pointer0 = ptrs[0];
   assign indirect_pointer1 = ptrs[1];
endmodule : dmiu_core
`default_nettype wire

// *** testbench/dmiu_core_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module dmiu_core_props #(
   parameter int PTR_W   = 16,
   parameter int NUM_PTR = 2
) (
   input wire logic             clock,
   input wire logic             rst,
   input wire logic             instr_valid,
   input wire logic [13:0]      instr,
   input wire logic [7:0]       mem_rdata,
   input wire logic [PTR_W-1:0] mem_addr,
   input wire logic             mem_rd,
   input wire logic             mem_wr,
   input wire logic [7:0]       mem_wdata,
   input wire logic [7:0]       acc,
   input wire logic [5:0]       bank_select_reg,
   input wire logic [6:0]       program_counter_high_latch,
   input wire logic [PTR_W-1:0] indirect_pointer0,
   input wire logic [PTR_W-1:0] indirect_pointer1,
   input wire logic             flags_we
);
   logic [PTR_W-1:0] sel, osel, step, ea;
   logic             ind, ofs;
   always_comb begin
      ind  = instr_valid && instr[13:4] == 10'h001;
      ofs  = instr_valid && instr[13:7] == 7'h7f;
      sel  = instr[2] ? indirect_pointer1 : indirect_pointer0;
      osel = instr[6] ? indirect_pointer1 : indirect_pointer0;
      step = instr[0] ? sel - 1'b1 : sel + 1'b1;
      ea   = instr[1] ? sel : step;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_ind_access;
      mem_addr == ea && mem_rd == !instr[3] && mem_wr == instr[3];
   endsequence
   sequence s_ind_update;
      ($past(instr[2]) ? indirect_pointer1 : indirect_pointer0) == $past(step);
   endsequence
   a_no_flag_write: assert property (flags_we == 1'b0) else $error("status write seen");
   a_bank_load: assert property (instr_valid && instr[13:6] == 8'h01 |=>
      bank_select_reg == $past(instr[5:0])) else $error("bank load wrong");
   a_latch_load: assert property (instr_valid && instr[13:7] == 7'h63 |=>
      program_counter_high_latch == $past(instr[6:0])) else $error("latch load wrong");
   a_acc_literal: assert property (instr_valid && instr[13:8] == 6'h30 |=>
      acc == $past(instr[7:0])) else $error("literal load wrong");
   a_file_store: assert property (instr_valid && instr[13:7] == 7'h01 |-> mem_wr && !mem_rd
      && mem_wdata == acc && mem_addr == PTR_W'({bank_select_reg, instr[6:0]})) else $error("file store wrong");
   a_ind_move: assert property (ind |-> s_ind_access ##1 s_ind_update)
      else $error("indirect move wrong");
   a_ind_load: assert property (ind && !instr[3] |=> acc == $past(mem_rdata))
      else $error("indirect load data wrong");
   a_ind_store: assert property (ind && instr[3] |-> mem_wdata == acc) else $error("store data wrong");
   a_ofs_store: assert property (ofs |-> mem_wr && mem_addr == osel + PTR_W'(signed'(instr[5:0]))
      ##1 $stable(indirect_pointer0) && $stable(indirect_pointer1)) else $error("offset store wrong");
   a_idle_quiet: assert property (!instr_valid |-> !mem_rd && !mem_wr) else $error("strobe while idle");
endmodule : dmiu_core_props
bind dmiu_core dmiu_core_props #(.PTR_W(PTR_W), .NUM_PTR(NUM_PTR)) props_u (.clock, .rst, .instr_valid,
   .instr, .mem_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .acc, .bank_select_reg,
   .program_counter_high_latch, .indirect_pointer0, .indirect_pointer1, .flags_we);
`default_nettype wire

// *** testbench/data_move_instruction_unit_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module data_move_instruction_unit_tb_top;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        instr_valid = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [7:0]  mem_rdata = 8'h00;
   logic [15:0] mem_addr, ip0, ip1, nx;
   logic [15:0] ex [2] = '{16'h0000, 16'h0000};
   logic        mem_rd, mem_wr, flags_we;
   logic [7:0]  mem_wdata, acc, ea;
   logic [5:0]  bank;
   logic [6:0]  latch;
   int          miscompares = 0;
   int          tests_run = 0;
   always #25 clock = ~clock;
   dmiu_core dut_u (.clock, .rst, .instr_valid, .instr, .mem_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
      .acc, .bank_select_reg(bank), .program_counter_high_latch(latch), .indirect_pointer0(ip0),
      .indirect_pointer1(ip1), .flags_we);
   // ----
   // drivers and checks
   // ----
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic tally_and_finish;
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   // inputs change at the falling edge; comb outputs read 5 ns later
   task automatic drive(input logic [13:0] w, input logic [7:0] rd);
      @(negedge clock);
      instr_valid = 1'b1;
      instr = w;
      mem_rdata = rd;
      #5;
   endtask : drive
   task automatic land;
      @(posedge clock);
      #1;
   endtask : land
   task automatic t_literals;
      drive(14'h007f, 8'h00);
      drive(14'h31ff, 8'h00);
      cmp(16'(bank), 16'h003f);
      drive(14'h30a5, 8'h00);
      cmp(16'(latch), 16'h007f);
      drive(14'h0055, 8'h00);
      land;
      ea = 8'ha5;
      cmp(16'(acc), 16'(ea));
      cmp(16'(bank), 16'h0015);
      cmp(16'(flags_we), 16'h0000);
   endtask : t_literals
   task automatic t_file_store;
      drive(14'h00ff, 8'h00);
      cmp(mem_addr, 16'({6'h15, 7'h7f}));
      cmp({7'h00, mem_wr, mem_wdata}, {8'h01, ea});
      land;
   endtask : t_file_store
   // walked downward so both wraps of pointer 1 occur first
   task automatic t_indirect;
      for (int i = 15; i >= 0; i--) begin
         nx = i[0] ? ex[i[2]] - 16'h0001 : ex[i[2]] + 16'h0001;
         drive(14'h0010 | 14'(i), 8'h40 + 8'(i));
         cmp(mem_addr, i[1] ? ex[i[2]] : nx);
         cmp({mem_rd, mem_wr, 6'h00, mem_wdata}, {!i[3], i[3], 6'h00, ea});
         land;
         ex[i[2]] = nx;
         ea = i[3] ? ea : 8'h40 + 8'(i);
         cmp(ip0, ex[0]);
         cmp(ip1, ex[1]);
         cmp(16'(acc), 16'(ea));
      end
   endtask : t_indirect
   // pointer 1 is stepped first so the two pointers differ
   task automatic t_offset;
      drive(14'h001e, 8'h00);
      cmp(mem_addr, ex[1]);
      land;
      ex[1] = ex[1] + 16'h0001;
      cmp(ip1, ex[1]);
      for (int j = 0; j < 4; j++) begin
         drive(14'h3f80 | (j[1] ? 14'h0040 : 14'h0000) | (j[0] ? 14'h001f : 14'h0020), 8'h00);
         cmp(mem_addr, ex[j[1]] + (j[0] ? 16'h001f : 16'hffe0));
         cmp(16'(mem_wr), 16'h0001);
         land;
         cmp(ip0, ex[0]);
         cmp(ip1, ex[1]);
      end
      @(negedge clock);
      instr_valid = 1'b0;
      #5;
      cmp(16'({mem_rd, mem_wr}), 16'h0000);
   endtask : t_offset
   // mid-run reset: registers clear without waiting for an edge
   task automatic t_reset;
      @(negedge clock);
      rst = 1'b1;
      #5;
      cmp(16'(acc), 16'h0000);
      cmp(16'({bank, latch}), 16'h0000);
      cmp(ip0, 16'h0000);
      cmp(ip1, 16'h0000);
      repeat (2) @(negedge clock);
      rst = 1'b0;
      ex = '{16'h0000, 16'h0000};
   endtask : t_reset
   initial begin
      repeat (20) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      t_literals;
      t_file_store;
      t_indirect;
      t_offset;
      t_reset;
      t_literals;
      tally_and_finish;
   end
   initial begin
      #100000;
      miscompares++;
      tally_and_finish;
   end
endmodule : data_move_instruction_unit_tb_top
`default_nettype wire
